// >>> src/time_code_converter.sv
`timescale 1ns/1ps
module time_code_converter
  import conv_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  input  wire logic      exec,
  input  wire conv_req_t req,
  output conv_rsp_t      rsp
);

  conv_state_t st_q;
  conv_state_t st_d;

  assign rsp = st_q.rsp;

  always_comb begin
    logic [31:0] src;
    logic [31:0] bin;
    logic [31:0] out;
    logic [31:0] rem;
    logic        bad;
    logic        dbl;
    logic [31:0] hh;
    logic [31:0] mm;
    logic [31:0] ss;
    src = {st_q.req.src_hi, st_q.req.src_lo};
    bin = '0;
    out = '0;
    rem = '0;
    bad = 1'b0;
    dbl = 1'b0;
    hh  = '0;
    mm  = '0;
    ss  = '0;
    st_d = st_q;
    st_d.rsp.done  = 1'b0;
    st_d.rsp.wr_lo = 1'b0;
    st_d.rsp.wr_hi = 1'b0;
    case (st_q.phase)
      ST_IDLE: begin
        if (exec) begin
          st_d.req   = req;
          st_d.phase = ST_CALC;
        end
      end
      ST_CALC: begin
        case (st_q.req.mode)
          packed_decimal_to_base2_word: begin
            bad = !digits_valid({16'h0000, st_q.req.src_lo});
            out = bcd_to_bin({16'h0000, st_q.req.src_lo});
          end
          packed_decimal_to_base2_double: begin
            dbl = 1'b1;
            bad = !digits_valid(src);
            out = bcd_to_bin(src);
          end
          base2_to_packed_decimal_word: begin
            bad = st_q.req.src_lo > BCD_WORD_LIMIT;
            out = bin_to_bcd({16'h0000, st_q.req.src_lo});
          end
          base2_to_packed_decimal_double: begin
            dbl = 1'b1;
            bad = src > BCD_DOUBLE_LIMIT;
            out = bin_to_bcd(src);
          end
          clock_time_to_total_seconds: begin
            dbl = 1'b1;
            // Seconds in low byte, minutes in high byte, hours in the upper word
            bad = !digits_valid(src) || st_q.req.src_lo[7:0] > TIME_FIELD_MAX
                  || st_q.req.src_lo[15:8] > TIME_FIELD_MAX;
            bad = bad || st_q.req.src_split || st_q.req.res_split;
            ss  = bcd_to_bin({24'h00_0000, st_q.req.src_lo[7:0]});
            mm  = bcd_to_bin({24'h00_0000, st_q.req.src_lo[15:8]});
            hh  = bcd_to_bin({16'h0000, st_q.req.src_hi});
            bin = 32'(hh * SEC_PER_HOUR) + 32'(mm * SEC_PER_MIN) + ss;
            out = bin_to_bcd(bin);
          end
          total_seconds_to_clock_time: begin
            dbl = 1'b1;
            bad = !digits_valid(src) || src >= SEC_BCD_LIMIT;
            bad = bad || st_q.req.src_split || st_q.req.res_split;
            bin = bcd_to_bin(src);
            hh  = bin / SEC_PER_HOUR;
            rem = bin % SEC_PER_HOUR;
            mm  = rem / SEC_PER_MIN;
            ss  = rem % SEC_PER_MIN;
            hh  = bin_to_bcd(hh);
            mm  = bin_to_bcd(mm);
            ss  = bin_to_bcd(ss);
            out = {hh[15:0], mm[7:0], ss[7:0]};
          end
          default: begin
            bad = 1'b1;
          end
        endcase
        if (st_q.req.ptr_used && (!digits_valid({16'h0000, st_q.req.ptr_word})
            || st_q.req.ptr_word > st_q.req.ptr_limit)) begin
          bad = 1'b1;
        end
        // Results and both flags appear in the same cycle as done
        st_d.rsp.done             = 1'b1;
        st_d.rsp.fault_flag       = bad;
        st_d.rsp.zero_result_flag = !bad && (dbl ? out == '0 : out[15:0] == '0);
        if (!bad) begin
          st_d.rsp.wr_lo  = 1'b1;
          st_d.rsp.wr_hi  = dbl;
          st_d.rsp.res_lo = out[15:0];
          if (dbl) begin
            st_d.rsp.res_hi = out[31:16];
          end
        end
        st_d.phase = ST_IDLE;
      end
      default: begin
        st_d.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic [31:0] cur_src;
  assign cur_src = {st_q.req.src_hi, st_q.req.src_lo};

  chk_exec_starts_one: assert property (
    (st_q.phase == ST_IDLE && exec) |-> ##2 (rsp.done && !$past(rsp.done)))
    else $error("request not answered two cycles later");

  chk_no_exec_quiet: assert property (
    (rsp.wr_lo || rsp.wr_hi || rsp.done) |-> $past(exec, 2))
    else $error("result written without execution condition");

  chk_word_bin_value: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == packed_decimal_to_base2_word
     && !st_q.req.ptr_used && digits_valid({16'h0000, st_q.req.src_lo}))
    |=> rsp.wr_lo && !rsp.wr_hi
        && rsp.res_lo == 16'(bcd_to_bin({16'h0000, $past(st_q.req.src_lo)})))
    else $error("word decimal-to-base2 value wrong");

  chk_word_bin_fault: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == packed_decimal_to_base2_word
     && !digits_valid({16'h0000, st_q.req.src_lo}))
    |=> rsp.fault_flag && !rsp.wr_lo && $stable(rsp.res_lo))
    else $error("non-decimal word did not fault");

  chk_zero_flag_follows: assert property (
    (rsp.done && rsp.wr_lo && !rsp.wr_hi) |-> rsp.zero_result_flag == (rsp.res_lo == '0))
    else $error("zero flag disagrees with word result");

  chk_word_bcd_limit: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == base2_to_packed_decimal_word
     && st_q.req.src_lo > BCD_WORD_LIMIT)
    |=> rsp.fault_flag && !rsp.wr_lo && $stable(rsp.res_lo))
    else $error("word source above limit not suppressed");

  chk_double_bcd_limit: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == base2_to_packed_decimal_double
     && cur_src > BCD_DOUBLE_LIMIT)
    |=> rsp.fault_flag && !rsp.wr_lo && !rsp.wr_hi && $stable(rsp.res_hi))
    else $error("double source above limit not suppressed");

  chk_double_bcd_value: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == base2_to_packed_decimal_double
     && !st_q.req.ptr_used && cur_src <= BCD_DOUBLE_LIMIT)
    |=> rsp.wr_hi && {rsp.res_hi, rsp.res_lo} == bin_to_bcd($past(cur_src)))
    else $error("double base2-to-decimal value wrong");

  chk_time_field_fault: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == clock_time_to_total_seconds
     && st_q.req.src_lo[7:0] > TIME_FIELD_MAX) |=> rsp.fault_flag)
    else $error("seconds field above 59 did not fault");

  chk_split_pair_fault: assert property (
    (st_q.phase == ST_CALC && (st_q.req.src_split || st_q.req.res_split)
     && (st_q.req.mode == clock_time_to_total_seconds
         || st_q.req.mode == total_seconds_to_clock_time))
    |=> rsp.fault_flag && !rsp.wr_lo)
    else $error("split pair did not fault");

  chk_sec_limit_fault: assert property (
    (st_q.phase == ST_CALC && st_q.req.mode == total_seconds_to_clock_time
     && cur_src >= SEC_BCD_LIMIT) |=> rsp.fault_flag)
    else $error("seconds above limit did not fault");

  chk_pointer_fault: assert property (
    (st_q.phase == ST_CALC && st_q.req.ptr_used
     && st_q.req.ptr_word > st_q.req.ptr_limit) |=> rsp.fault_flag && !rsp.wr_lo)
    else $error("missing indirect word did not fault");

  cov_double_to_bin: cover property (
    rsp.done && rsp.wr_hi && st_q.req.mode == packed_decimal_to_base2_double);
  cov_clock_to_sec: cover property (
    rsp.done && !rsp.fault_flag && st_q.req.mode == clock_time_to_total_seconds);
  cov_sec_to_clock: cover property (
    rsp.done && !rsp.fault_flag && st_q.req.mode == total_seconds_to_clock_time);
  cov_zero_result: cover property (rsp.done && rsp.zero_result_flag);
  cov_back_to_back: cover property (rsp.done ##2 rsp.done);

endmodule

// >>> src/conv_pkg.sv
package conv_pkg;

  localparam logic [3:0]  BCD_DIGIT_MAX    = 4'h9;
  localparam logic [15:0] BCD_WORD_LIMIT   = 16'h270F;
  localparam logic [31:0] BCD_DOUBLE_LIMIT = 32'h05F5_E0FF;
  localparam logic [7:0]  TIME_FIELD_MAX   = 8'h59;
  localparam logic [31:0] SEC_BCD_LIMIT    = 32'h3600_0000;
  localparam logic [31:0] SEC_PER_HOUR     = 32'h0000_0E10;
  localparam logic [31:0] SEC_PER_MIN      = 32'h0000_003C;
  localparam logic [31:0] DECIMAL_BASE     = 32'h0000_000A;

  typedef enum logic [2:0] {
    packed_decimal_to_base2_word,
    packed_decimal_to_base2_double,
    base2_to_packed_decimal_word,
    base2_to_packed_decimal_double,
    clock_time_to_total_seconds,
    total_seconds_to_clock_time
  } conv_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CALC
  } conv_phase_t;

  typedef struct packed {
    conv_mode_t  mode;
    logic [15:0] src_lo;
    logic [15:0] src_hi;
    logic        src_split;
    logic        res_split;
    logic        ptr_used;
    logic [15:0] ptr_word;
    logic [15:0] ptr_limit;
  } conv_req_t;

  typedef struct packed {
    logic [15:0] res_lo;
    logic [15:0] res_hi;
    logic        wr_lo;
    logic        wr_hi;
    logic        done;
    logic        fault_flag;
    logic        zero_result_flag;
  } conv_rsp_t;

  typedef struct packed {
    conv_phase_t phase;
    conv_req_t   req;
    conv_rsp_t   rsp;
  } conv_state_t;

  function automatic logic digits_valid(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (v[4*i +: 4] > BCD_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
    logic [31:0] acc;
    acc = '0;
    for (int i = 7; i >= 0; i--) begin
      acc = 32'(acc * DECIMAL_BASE) + {28'h000_0000, v[4*i +: 4]};
    end
    return acc;
  endfunction

  function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
    logic [31:0] bcd;
    bcd = '0;
    for (int i = 31; i >= 0; i--) begin
      for (int d = 0; d < 8; d++) begin
        if (bcd[4*d +: 4] > 4'h4) begin
          bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
        end
      end
      bcd = {bcd[30:0], v[i]};
    end
    return bcd;
  endfunction

endpackage

// >>> verif/seq_model.sv
`timescale 1ns/1ps
module seq_model
  import conv_pkg::*;
(
  input  wire logic sys_clk,
  output logic      exec,
  output conv_req_t req
);
  initial begin
    exec = 1'b0;
    req  = '0;
  end

  // One taking edge per request; operands are scrambled once the edge has passed
  task automatic issue(input conv_req_t r);
    @(negedge sys_clk);
    exec <= 1'b1;
    req  <= r;
    @(negedge sys_clk);
    exec <= 1'b0;
    req  <= ~r;
  endtask
endmodule

// >>> verif/time_code_converter_tb_top.sv
`timescale 1ns/1ps
module time_code_converter_tb_top;
  import conv_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        exec;
  conv_req_t   req;
  conv_rsp_t   rsp;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'h4abd_00ec;
  logic [15:0] e_lo = 16'h0000;
  logic [15:0] e_hi = 16'h0000;

  always #50 sys_clk = ~sys_clk;

  time_code_converter u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .exec(exec), .req(req), .rsp(rsp));
  seq_model u_seq (.sys_clk(sys_clk), .exec(exec), .req(req));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic isdec(input logic [31:0] v);
    for (int i = 0; i < 8; i++) if (v[4*i +: 4] > 4'h9) return 1'b0;
    return 1'b1;
  endfunction

  function automatic logic [31:0] d2b(input logic [31:0] v);
    logic [31:0] a;
    a = 0;
    for (int i = 7; i >= 0; i--) a = a * 10 + v[4*i +: 4];
    return a;
  endfunction

  function automatic logic [31:0] b2d(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      r[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  // Flags: [0] source pair split, [1] result pair split, [2] pointer used, [3] pointer too high
  function automatic conv_req_t mk(input conv_mode_t m, input logic [31:0] v, input logic [3:0] f);
    mk = '{m, v[15:0], v[31:16], f[0], f[1], f[2], 16'h0050, f[3] ? 16'h0040 : 16'h0500};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic run(input conv_req_t r);
    logic f, w;
    logic [31:0] v, s, res, h, m, x;
    v = {r.src_hi, r.src_lo};
    w = 1'b1;
    case (r.mode)
      packed_decimal_to_base2_word: begin
        w = 1'b0;
        f = !isdec({16'h0000, r.src_lo});
        res = d2b({16'h0000, r.src_lo});
      end
      packed_decimal_to_base2_double: begin
        f = !isdec(v);
        res = d2b(v);
      end
      base2_to_packed_decimal_word: begin
        w = 1'b0;
        f = r.src_lo > 16'h270F;
        res = b2d({16'h0000, r.src_lo});
      end
      base2_to_packed_decimal_double: begin
        f = v > 32'h05F5_E0FF;
        res = b2d(v);
      end
      clock_time_to_total_seconds: begin
        f = !isdec(v) || r.src_lo[7:0] > 8'h59 || r.src_lo[15:8] > 8'h59;
        s = d2b(32'(r.src_hi)) * 3600 + d2b(32'(r.src_lo[15:8])) * 60;
        res = b2d(s + d2b(32'(r.src_lo[7:0])));
      end
      default: begin
        f = !isdec(v) || v >= 32'h3600_0000;
        s = d2b(v);
        h = b2d(s / 3600);
        m = b2d(s / 60 % 60);
        x = b2d(s % 60);
        res = {h[15:0], m[7:0], x[7:0]};
      end
    endcase
    if (r.mode inside {clock_time_to_total_seconds, total_seconds_to_clock_time})
      f |= r.src_split || r.res_split;
    f |= r.ptr_used && (!isdec({16'h0000, r.ptr_word}) || r.ptr_word > r.ptr_limit);
    u_seq.issue(r);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      #1;
      if (rsp.done === 1'b1) break;
    end
    if (!f) begin
      e_lo = res[15:0];
      if (w) e_hi = res[31:16];
    end
    chk(32'(rsp.done), 32'h0000_0001, "done");
    chk(32'(rsp.fault_flag), 32'(f), "fault");
    chk(32'(rsp.zero_result_flag), 32'(!f && (w ? res == 0 : res[15:0] == 0)), "zero");
    chk(32'(rsp.res_lo), 32'(e_lo), "res_lo");
    chk(32'(rsp.res_hi), 32'(e_hi), "res_hi");
    chk(32'({rsp.wr_hi, rsp.wr_lo}), 32'({!f && w, !f}), "write strobes");
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #5_000_000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    logic [31:0] r1, r2, v;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    chk({rsp.res_hi, rsp.res_lo}, 32'h0000_0000, "reset results");
    chk({27'h000_0000, rsp.wr_lo, rsp.wr_hi, rsp.done, rsp.fault_flag, rsp.zero_result_flag},
        32'h0000_0000, "reset flags");
    run(mk(packed_decimal_to_base2_word, 32'h0000_1234, 4'h0));
    run(mk(packed_decimal_to_base2_word, 32'h0000_0000, 4'h0));
    run(mk(packed_decimal_to_base2_word, 32'h0000_12A4, 4'h0));
    run(mk(packed_decimal_to_base2_double, 32'h9999_9999, 4'h0));
    run(mk(packed_decimal_to_base2_double, 32'hF000_0001, 4'h0));
    run(mk(base2_to_packed_decimal_word, 32'h0000_270F, 4'h0));
    run(mk(base2_to_packed_decimal_word, 32'h0000_2710, 4'h0));
    run(mk(base2_to_packed_decimal_double, 32'h05F5_E0FF, 4'h0));
    run(mk(base2_to_packed_decimal_double, 32'h05F5_E100, 4'h0));
    run(mk(clock_time_to_total_seconds, 32'h9999_5959, 4'h0));
    run(mk(clock_time_to_total_seconds, 32'h0001_6000, 4'h0));
    run(mk(clock_time_to_total_seconds, 32'h0001_0060, 4'h0));
    run(mk(clock_time_to_total_seconds, 32'h0001_0000, 4'h1));
    run(mk(total_seconds_to_clock_time, 32'h3599_9999, 4'h0));
    run(mk(total_seconds_to_clock_time, 32'h3600_0000, 4'h0));
    run(mk(total_seconds_to_clock_time, 32'h0000_3600, 4'h2));
    run(mk(packed_decimal_to_base2_word, 32'h0000_0042, 4'h4));
    run(mk(base2_to_packed_decimal_word, 32'h0000_0042, 4'hC));
    $display("test corner cases done");
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      chk(32'(rsp.done), 32'h0000_0000, "idle done");
      chk({rsp.res_hi, rsp.res_lo}, {e_hi, e_lo}, "idle results");
    end
    $display("test idle done");
    for (int i = 0; i < 120; i++) begin
      r1 = rnd();
      r2 = rnd();
      v = r1[9] ? r2 : (r1[8] ? r2 % 36000000 : b2d(r2 % 100000000));
      req_rand(r1, v);
    end
    $display("test random done");
    wrap_up();
  end

  task automatic req_rand(input logic [31:0] r1, input logic [31:0] v);
    conv_req_t r;
    r = mk(conv_mode_t'(3'(r1 % 6)), v, {1'b0, r1[12], r1[13] & r1[14], r1[15] & r1[16]});
    if (r1[10]) r.ptr_word = 16'h00A0;
    run(r);
  endtask
endmodule
